// ---- core/ast_pkg.sv ----
package ast_pkg;

  // ****************************************************************
  // Register map (byte addresses on the APB)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL_THREE = 8'h00;
  localparam logic [7:0] OFS_DATA_PORT  = 8'h04;
  localparam logic [7:0] OFS_TX_CTRL    = 8'h08;
  localparam logic [7:0] OFS_STATUS     = 8'h0C;
  localparam logic [7:0] OFS_BAUD       = 8'h10;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  // control_three
  localparam int C3_RX_NINTH  = 7;
  localparam int C3_TX_NINTH  = 6;
  localparam int C3_SW_DIR    = 5;
  localparam int C3_TX_INV    = 4;
  localparam int C3_OR_IE     = 3;
  localparam int C3_NOISE_IE  = 2;
  localparam int C3_FRAME_IE  = 1;
  localparam int C3_PARITY_IE = 0;
  // Transmit control
  localparam int TC_TX_EN     = 0;
  localparam int TC_SBK       = 1;
  localparam int TC_NINE      = 2;
  localparam int TC_LONG_BRK  = 3;
  localparam int TC_LOOP      = 4;
  localparam int TC_RX_SOURCE_SELECT      = 5;
  localparam int TC_TX_BUFFER_EMPTY_IE   = 6;
  localparam int TC_TC_IE     = 7;
  // Status
  localparam int ST_TX_BUFFER_EMPTY      = 0;
  localparam int ST_TC        = 1;
  localparam int ST_PARITY    = 2;
  localparam int ST_FRAMING   = 3;
  localparam int ST_NOISE     = 4;
  localparam int ST_OVERRUN   = 5;
  localparam int ST_RX_FULL   = 6;

  // ****************************************************************
  // Reset values and frame lengths in bit times
  // ****************************************************************
  localparam logic [7:0]  CTRL_THREE_RST = 8'h00;
  localparam logic [7:0]  TX_CTRL_RST    = 8'h00;
  localparam logic [12:0] BAUD_RST       = 13'h0001;
  localparam logic [3:0]  LEN_FRAME8     = 4'hA;
  localparam logic [3:0]  LEN_FRAME9     = 4'hB;
  localparam logic [3:0]  LEN_BRK_LONG8  = 4'hD;
  localparam logic [3:0]  LEN_BRK_LONG9  = 4'hE;

  // Receive-side status delivered by the receiver half
  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
    logic       full;
    logic       overrun;
    logic       noise;
    logic       framing;
    logic       parity;
  } ast_rx_stat_t;

  // Transmit pin and interrupt requests
  typedef struct packed {
    logic line;
    logic oe;
    logic tx_irq;
    logic err_irq;
  } ast_pin_t;

  // What the shifter is carrying
  typedef enum logic [1:0] {
    SH_IDLE  = 2'b00,
    SH_DATA  = 2'b01,
    SH_PRE   = 2'b10,
    SH_BREAK = 2'b11
  } ast_shift_t;

endpackage

// ---- core/ast_transmitter.sv ----
// Overview of operation
// [RULE1] Software reads received ninth bit before data port in nine-bit mode.
// [RULE2] Nine-bit data port write also sends stored transmit ninth bit.
// [RULE3] Single-wire mode: bit 5 makes transmit pin input or output.
// [RULE4] Invert bit 4 flips every level on the serial output.
// [RULE5] Bit 3 gates the overrun flag onto the error interrupt.
// [RULE6] Bit 2 gates the noise flag onto the error interrupt.
// [RULE7] Bit 1 gates the framing flag onto the error interrupt.
// [RULE8] Bit 0 gates the parity flag onto the error interrupt.
// [RULE9] Data port read returns receive buffer, write loads transmit buffer.
// [RULE10] One baud generator from the bus clock serves both directions.
// [RULE11] Remote end matches baud rate within about four percent.
// [RULE12] Invert bit resets to zero so the line idles high.
// [RULE13] Enabling the transmitter queues one idle preamble frame.
// [RULE14] Shifter is 10 bits, or 11 in nine-bit mode, framed.
// [RULE15] Free shifter takes buffer on baud tick and sets buffer empty.
// [RULE16] Stop bit out with nothing waiting sets transmit complete.
// [RULE17] Disabling keeps the pin until current and queued frames finish.
// [RULE18] Send-break toggle queues a break; still set at load queues another.
// [RULE19] Break lengths are 10, 11, 13 or 14 bit times.
// [RULE20] Clearing then setting enable queues one idle character.
// [RULE21] Software waits for buffer empty before queuing break or idle.
// [RULE22] Frame is start 0, data LSB first, stop 1.
// [RULE23] Transmit events and error events drive separate interrupts.
// [RULE24] Buffer empty clears on status read then data write.
`timescale 1ns/1ps
`default_nettype none

module ast_transmitter #(
  parameter logic [12:0] BAUD_DEFAULT = 13'h0001
) (
  input  wire logic                  pclk,    // Bus clock, 40 MHz
  input  wire logic                  presetn, // Async reset, active low
  input  wire logic                  psel,    // APB select
  input  wire logic                  penable, // APB access phase
  input  wire logic                  pwrite,  // APB direction
  input  wire logic [7:0]            paddr,   // APB byte address
  input  wire logic [31:0]           pwdata,  // APB write data
  output logic      [31:0]           prdata,  // APB read data
  output logic                       pready,  // APB ready
  output logic                       pslverr, // APB error
  input  wire ast_pkg::ast_rx_stat_t rx_stat, // Receiver status in
  output logic                       rx_rd,   // Data port read pulse
  output ast_pkg::ast_pin_t          pin      // Transmit pin and irqs
);
  import ast_pkg::*;

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  logic [7:0]  c3_reg;
  logic [7:0]  txc_reg;
  logic [12:0] baud_reg;
  logic [12:0] bcnt_reg;
  logic [7:0]  tbuf_reg;
  logic        tx_buffer_empty_reg;
  logic        tc_reg;
  logic        armed_reg;
  logic        pre_pend_reg;
  logic        brk_pend_reg;
  logic [13:0] shift_reg;
  logic [3:0]  left_reg;
  ast_shift_t  kind_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        rx_rd_reg;
  ast_pin_t    pin_reg;
  logic        acc_done;
  logic        wr_en;
  logic        rd_en;
  logic        mapped;
  logic        tick;
  logic        free_now;
  logic        load_pre;
  logic        load_brk;
  logic        load_dat;
  logic        any_load;
  logic        stop_done;
  logic [3:0]  frame_len;
  logic [3:0]  brk_len;
  logic [7:0]  st_word;
  logic [31:0] rd_mux;
  logic        owns;

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // Access completes on the second access cycle
  assign acc_done = psel & penable & pready_reg;
  assign wr_en    = acc_done & pwrite & ~pslverr_reg;
  assign rd_en    = acc_done & ~pwrite & ~pslverr_reg;
  // Address decode
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr == OFS_CTRL_THREE) begin
      rd_mux[7:0] = {rx_stat.ninth, c3_reg[6:0]};
    end else if (paddr == OFS_DATA_PORT) begin
      rd_mux[7:0] = rx_stat.data; // [RULE9]
    end else if (paddr == OFS_TX_CTRL) begin
      rd_mux[7:0] = txc_reg;
    end else if (paddr == OFS_STATUS) begin
      rd_mux[7:0] = st_word;
    end else if (paddr == OFS_BAUD) begin
      rd_mux[12:0] = baud_reg;
    end else begin
      mapped = 1'b0;
    end
  end
  // Status word
  always_comb begin
    st_word              = 8'h00;
    st_word[ST_TX_BUFFER_EMPTY]     = tx_buffer_empty_reg;
    st_word[ST_TC]       = tc_reg;
    st_word[ST_PARITY]   = rx_stat.parity;
    st_word[ST_FRAMING]  = rx_stat.framing;
    st_word[ST_NOISE]    = rx_stat.noise;
    st_word[ST_OVERRUN]  = rx_stat.overrun;
    st_word[ST_RX_FULL]  = rx_stat.full;
  end
  // Ready, read data and error answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (psel && penable && !pready_reg) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= ~mapped;
      prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end
  // Receiver told of a data port read to finish its flag clearing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_rd_reg <= 1'b0;
    end else begin
      rx_rd_reg <= rd_en && (paddr == OFS_DATA_PORT); // [RULE9] [RULE1]
    end
  end
  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c3_reg   <= CTRL_THREE_RST; // [RULE12]
      txc_reg  <= TX_CTRL_RST;
      baud_reg <= BAUD_DEFAULT;
    end else if (wr_en) begin
      if (paddr == OFS_CTRL_THREE) begin
        c3_reg <= {1'b0, pwdata[6:0]};
      end else if (paddr == OFS_TX_CTRL) begin
        txc_reg <= pwdata[7:0];
      end else if (paddr == OFS_BAUD) begin
        baud_reg <= pwdata[12:0];
      end
    end
  end

  // ****************************************************************
  // Baud generator
  // ****************************************************************
  // One bit-time tick from the bus clock; zero divisor stops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_reg <= 13'h0000;
    end else if (baud_reg == 13'h0000) begin
      bcnt_reg <= 13'h0000;
    end else if (bcnt_reg >= baud_reg - 13'h0001) begin
      bcnt_reg <= 13'h0000; // [RULE10]
    end else begin
      bcnt_reg <= bcnt_reg + 13'h0001;
    end
  end
  assign tick = (baud_reg != 13'h0000) &&
                (bcnt_reg >= baud_reg - 13'h0001);

  // ****************************************************************
  // Transmit buffer and flags
  // ****************************************************************
  assign frame_len = txc_reg[TC_NINE] ? LEN_FRAME9 : LEN_FRAME8; // [RULE14]
  // Break length from long-break and nine-bit selects
  always_comb begin
    case ({txc_reg[TC_LONG_BRK], txc_reg[TC_NINE]})
      2'b00:   brk_len = LEN_FRAME8; // [RULE19]
      2'b01:   brk_len = LEN_FRAME9;
      2'b10:   brk_len = LEN_BRK_LONG8;
      default: brk_len = LEN_BRK_LONG9;
    endcase
  end
  // Load priority when the shifter frees: preamble, break, data
  assign free_now  = tick && (left_reg <= 4'h1);
  assign load_pre  = free_now && pre_pend_reg;
  assign load_brk  = free_now && !pre_pend_reg && brk_pend_reg;
  assign load_dat  = free_now && !pre_pend_reg && !brk_pend_reg &&
                     !tx_buffer_empty_reg && txc_reg[TC_TX_EN];
  assign any_load  = load_pre | load_brk | load_dat;
  assign stop_done = tick && (left_reg == 4'h1) && !any_load;
  // Transmit buffer written from the data port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbuf_reg <= 8'h00;
    end else if (wr_en && paddr == OFS_DATA_PORT) begin
      tbuf_reg <= pwdata[7:0]; // [RULE9]
    end
  end
  // Status read with buffer empty set arms the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 1'b0;
    end else if (rd_en && paddr == OFS_STATUS && tx_buffer_empty_reg) begin
      armed_reg <= 1'b1; // [RULE24]
    end else if (wr_en && paddr == OFS_DATA_PORT) begin
      armed_reg <= 1'b0;
    end
  end
  // Buffer empty flag: transfer sets and wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buffer_empty_reg <= 1'b1;
    end else if (load_dat) begin
      tx_buffer_empty_reg <= 1'b1; // [RULE15]
    end else if (wr_en && paddr == OFS_DATA_PORT && armed_reg) begin
      tx_buffer_empty_reg <= 1'b0; // [RULE24]
    end
  end
  // Complete flag: set after last stop bit, cleared by a new frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tc_reg <= 1'b1;
    end else if (stop_done) begin
      tc_reg <= 1'b1; // [RULE16]
    end else if (any_load) begin
      tc_reg <= 1'b0; // [RULE24]
    end
  end
  // Preamble queued on each rising edge of the enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_pend_reg <= 1'b0;
    end else if (wr_en && paddr == OFS_TX_CTRL && pwdata[TC_TX_EN] &&
                 !txc_reg[TC_TX_EN]) begin
      pre_pend_reg <= 1'b1; // [RULE13] [RULE20]
    end else if (load_pre) begin
      pre_pend_reg <= 1'b0;
    end
  end
  // Break queued by send-break, again if still set at load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_pend_reg <= 1'b0;
    end else if (wr_en && paddr == OFS_TX_CTRL && pwdata[TC_SBK] &&
                 !txc_reg[TC_SBK]) begin
      brk_pend_reg <= 1'b1; // [RULE18]
    end else if (load_brk) begin
      brk_pend_reg <= txc_reg[TC_SBK]; // [RULE18]
    end
  end

  // ****************************************************************
  // Shifter
  // ****************************************************************
  // Frame is shifted LSB first; empty slots fill with stop level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= 14'h3FFF;
      left_reg  <= 4'h0;
      kind_reg  <= SH_IDLE;
    end else if (load_pre) begin
      shift_reg <= 14'h3FFF; // [RULE13]
      left_reg  <= frame_len;
      kind_reg  <= SH_PRE;
    end else if (load_brk) begin
      shift_reg <= 14'h0000; // [RULE19]
      left_reg  <= brk_len;
      kind_reg  <= SH_BREAK;
    end else if (load_dat) begin
      if (txc_reg[TC_NINE]) begin
        shift_reg <= {3'b111, 1'b1, c3_reg[C3_TX_NINTH], tbuf_reg,
                      1'b0}; // [RULE2] [RULE22]
      end else begin
        shift_reg <= {4'hF, 1'b1, tbuf_reg, 1'b0}; // [RULE22]
      end
      left_reg <= frame_len; // [RULE14]
      kind_reg <= SH_DATA;
    end else if (tick && left_reg > 4'h1) begin
      shift_reg <= {1'b1, shift_reg[13:1]};
      left_reg  <= left_reg - 4'h1;
    end else if (tick && left_reg == 4'h1) begin
      shift_reg <= 14'h3FFF; // [RULE16]
      left_reg  <= 4'h0;
      kind_reg  <= SH_IDLE;
    end
  end
  // Pin stays ours while enabled or anything is under way
  assign owns = txc_reg[TC_TX_EN] || (left_reg != 4'h0) ||
                pre_pend_reg || brk_pend_reg; // [RULE17] [RULE20]
  // Pin, direction and interrupt outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_reg <= '{line: 1'b1, oe: 1'b0, tx_irq: 1'b0, err_irq: 1'b0};
    end else begin
      pin_reg.line <= ((left_reg != 4'h0) ? shift_reg[0] : 1'b1) ^
                      c3_reg[C3_TX_INV]; // [RULE4] [RULE12]
      if (txc_reg[TC_LOOP] && txc_reg[TC_RX_SOURCE_SELECT]) begin
        pin_reg.oe <= owns & c3_reg[C3_SW_DIR]; // [RULE3]
      end else begin
        pin_reg.oe <= owns;
      end
      pin_reg.tx_irq <= (tx_buffer_empty_reg & txc_reg[TC_TX_BUFFER_EMPTY_IE]) |
                        (tc_reg & txc_reg[TC_TC_IE]); // [RULE23]
      pin_reg.err_irq <= (rx_stat.overrun & c3_reg[C3_OR_IE]) | // [RULE5]
                         (rx_stat.noise & c3_reg[C3_NOISE_IE]) | // [RULE6]
                         (rx_stat.framing & c3_reg[C3_FRAME_IE]) | // [RULE7]
                         (rx_stat.parity & c3_reg[C3_PARITY_IE]); // [RULE8]
    end
  end
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign rx_rd   = rx_rd_reg;
  assign pin     = pin_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_line_inverted;
    @(posedge pclk) disable iff (!presetn)
      ($past(left_reg) == 4'h0) |-> (pin.line == ~$past(c3_reg[C3_TX_INV]));
  endproperty
  a_line_inverted: assert property (p_line_inverted) // [RULE4]
    else $error("idle line level wrong for invert setting");
  property p_single_wire_in;
    @(posedge pclk) disable iff (!presetn)
      (txc_reg[TC_LOOP] && txc_reg[TC_RX_SOURCE_SELECT] && !c3_reg[C3_SW_DIR])
        |=> !pin.oe;
  endproperty
  a_single_wire_in: assert property (p_single_wire_in) // [RULE3]
    else $error("pin driven in single-wire input mode");
  property p_err_irq;
    @(posedge pclk) disable iff (!presetn)
      (rx_stat.overrun && c3_reg[C3_OR_IE]) ||
      (rx_stat.noise && c3_reg[C3_NOISE_IE]) |=> pin.err_irq;
  endproperty
  a_err_irq: assert property (p_err_irq) // [RULE5]
    else $error("enabled error flag gave no interrupt");
  property p_err_quiet;
    @(posedge pclk) disable iff (!presetn)
      ((c3_reg[3:0] & {rx_stat.overrun, rx_stat.noise, rx_stat.framing,
                        rx_stat.parity}) == 4'h0) |=> !pin.err_irq;
  endproperty
  a_err_quiet: assert property (p_err_quiet) // [RULE8]
    else $error("error interrupt without enabled flag");
  property p_tx_buffer_empty_on_load;
    @(posedge pclk) disable iff (!presetn)
      load_dat |=> tx_buffer_empty_reg && kind_reg == SH_DATA && left_reg == frame_len;
  endproperty
  a_tx_buffer_empty_on_load: assert property (p_tx_buffer_empty_on_load) // [RULE15]
    else $error("buffer transfer did not set empty flag");
  property p_tc_set;
    @(posedge pclk) disable iff (!presetn)
      $rose(tc_reg) |-> $past(left_reg) == 4'h1 && $past(tick);
  endproperty
  a_tc_set: assert property (p_tc_set) // [RULE16]
    else $error("complete flag set outside end of stop bit");
  property p_tc_clear;
    @(posedge pclk) disable iff (!presetn)
      $fell(tc_reg) |-> $past(any_load);
  endproperty
  a_tc_clear: assert property (p_tc_clear) // [RULE24]
    else $error("complete flag cleared without a new frame");
  property p_brk_len;
    @(posedge pclk) disable iff (!presetn)
      load_brk |=> left_reg == brk_len && shift_reg == 14'h0000;
  endproperty
  a_brk_len: assert property (p_brk_len) // [RULE19]
    else $error("break loaded with wrong length");
  property p_preamble;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == OFS_TX_CTRL && pwdata[TC_TX_EN] &&
       !txc_reg[TC_TX_EN]) |=> pre_pend_reg && owns;
  endproperty
  a_preamble: assert property (p_preamble) // [RULE13]
    else $error("enable rise queued no preamble");
  property p_rd_pulse;
    @(posedge pclk) disable iff (!presetn)
      rx_rd |-> $past(rd_en) && $past(paddr) == OFS_DATA_PORT ##1 !rx_rd;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) // [RULE9]
    else $error("data read pulse not tied to a data port read");
  c_break:    cover property (@(posedge pclk) load_brk);
  c_data:     cover property (@(posedge pclk) load_dat ##1 tx_buffer_empty_reg);
  c_preamble: cover property (@(posedge pclk) load_pre);
  c_complete: cover property (@(posedge pclk) $rose(tc_reg));

endmodule

`default_nettype wire

// ---- verification/ast_serial_peer.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Remote receiver on the serial line
// ****************************************************************
module ast_serial_peer #(
  parameter int DIV = 16
) (
  input  wire logic clk,     // Bus clock reference
  input  wire logic line,    // Serial line from the block
  input  wire logic inv,     // Line polarity inverted
  input  wire logic nine,    // Nine data bits a frame
  output logic [8:0] word,   // Last data received
  output logic       stop_ok,// Last stop bit was high
  output int         frames, // Frames received
  output int         low_len // Last low run in cycles
);
  logic [8:0] w;
  int         run;

  // Same bit time as the block, sampled mid-bit
  initial begin
    frames = 0;
    word = 9'h000;
    stop_ok = 1'b0;
    forever begin
      @(posedge clk);
      if ((line ^ inv) === 1'b0) begin
        repeat (DIV / 2) @(posedge clk);
        if ((line ^ inv) !== 1'b0) continue;
        w = 9'h000;
        // Start low, data LSB first, stop high
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
          repeat (DIV) @(posedge clk);
          w[i] = line ^ inv;
        end
        repeat (DIV) @(posedge clk);
        stop_ok = line ^ inv;
        word = w;
        frames++;
        while ((line ^ inv) !== 1'b1) @(posedge clk);
      end
    end
  end

  // Length of each low run, for break timing
  initial begin
    run = 0;
    low_len = 0;
    forever begin
      @(posedge clk);
      if ((line ^ inv) === 1'b0) begin
        run++;
      end else begin
        if (run > 0) low_len = run;
        run = 0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import ast_pkg::*;
  localparam int DIV = 16;
  logic              pclk, presetn, psel, penable, pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              pready, pslverr, rx_rd, inv, nine, err, stop_ok;
  logic [8:0]        word;
  ast_rx_stat_t      rx_stat;
  ast_pin_t          pin;
  int                frames, low_len, err_count, num_checks, pulses, f;
  int                lens [4] = '{10, 11, 13, 14};

  // ****************************************************************
  // Clock, design and far end
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  ast_transmitter dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_stat(rx_stat), .rx_rd(rx_rd), .pin(pin));

  ast_serial_peer #(.DIV(DIV)) peer (.clk(pclk), .line(pin.line),
    .inv(inv), .nine(nine), .word(word), .stop_ok(stop_ok),
    .frames(frames), .low_len(low_len));

  // Count receive-read pulses
  always @(posedge pclk) begin
    if (rx_rd === 1'b1) pulses++;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: %s", $time, m);
      err_count++;
    end
  endtask

  task automatic stop(input string m);
    chk(32'h1, 32'h0, m);
    end_sim();
  endtask

  // One APB transfer, held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) stop("apb hang");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_tc();
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[ST_TC] !== 1'b1 && n < 300);
    if (n >= 300) stop("tc hang");
  endtask

  // Send one byte, optionally disabling once it is in the shifter
  task automatic send(input logic [7:0] b, input logic [8:0] e,
                      input logic dis);
    int n;
    f = frames;
    apb(1'b0, OFS_STATUS, 32'h0);
    apb(1'b1, OFS_DATA_PORT, {24'h0, b});
    if (dis) begin
      repeat (DIV + 2) @(posedge pclk);
      apb(1'b1, OFS_TX_CTRL, 32'h0);
      repeat (2) @(posedge pclk);
      chk(32'(pin.oe), 32'h1, "pin held");
    end
    n = 0;
    while (frames == f && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) stop("no frame");
    chk(32'(word), 32'(e), "frame data");
    chk(32'(stop_ok), 32'h1, "stop bit");
    wait_tc();
    chk(32'(pin.line), {31'h0, ~inv}, "idle level");
    chk(32'(pin.oe), {31'h0, ~dis}, "pin owner");
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    {presetn, psel, penable, pwrite, inv, nine} = 6'h00;
    {paddr, pwdata} = 40'h0;
    rx_stat = '0;
    {err_count, num_checks, pulses} = 96'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL_THREE, 32'h0);
    chk(rd, 32'h0, "c3 reset");
    chk(32'(pin.line), 32'h1, "reset line");
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(err), 32'h1, "unmapped");
    apb(1'b1, OFS_BAUD, DIV);
    apb(1'b1, OFS_TX_CTRL, 32'h1);
    repeat (2 * DIV) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(rd[ST_TC]), 32'h0, "preamble busy");
    wait_tc();
    chk(frames, 0, "preamble idle");
    chk(32'(pin.oe), 32'h1, "drive pin");
    send(8'hA5, 9'h0A5, 1'b0);
    nine = 1'b1;
    apb(1'b1, OFS_TX_CTRL, 32'h5);
    apb(1'b1, OFS_CTRL_THREE, 32'h40);
    send(8'h3C, 9'h13C, 1'b0);
    send(8'h81, 9'h181, 1'b0);
    nine = 1'b0;
    apb(1'b1, OFS_TX_CTRL, 32'h1);
    apb(1'b1, OFS_CTRL_THREE, 32'h10);
    inv = 1'b1;
    repeat (4) @(posedge pclk);
    chk(32'(pin.line), 32'h0, "inverted idle");
    send(8'h96, 9'h096, 1'b0);
    apb(1'b1, OFS_CTRL_THREE, 32'h0);
    inv = 1'b0;
    send(8'h6E, 9'h06E, 1'b1);
    f = frames;
    apb(1'b1, OFS_TX_CTRL, 32'h1);
    repeat (2 * DIV) @(posedge pclk);
    wait_tc();
    chk(frames, f, "idle char");
    // Breaks queued with the bit clock held, then released
    for (int s = 0; s < 4; s++) begin
      nine = s[0];
      apb(1'b1, OFS_BAUD, 32'h0);
      apb(1'b1, OFS_TX_CTRL, {28'h0, s[1:0], 2'b11});
      apb(1'b1, OFS_TX_CTRL, {28'h0, s[1:0], 2'b01});
      apb(1'b1, OFS_BAUD, DIV);
      repeat (2 * DIV) @(posedge pclk);
      wait_tc();
      chk(low_len, lens[s] * DIV, "break length");
    end
    nine = 1'b0;
    apb(1'b1, OFS_TX_CTRL, 32'h3);
    repeat (6 * DIV) @(posedge pclk);
    apb(1'b1, OFS_TX_CTRL, 32'h1);
    wait_tc();
    chk(low_len, 20 * DIV, "requeued break");
    for (int i = 0; i < 4; i++) begin
      rx_stat <= ast_rx_stat_t'(14'h1 << i);
      apb(1'b1, OFS_CTRL_THREE, 32'hF & ~(32'h1 << i));
      repeat (2) @(posedge pclk);
      chk(32'(pin.err_irq), 32'h0, "masked");
      apb(1'b1, OFS_CTRL_THREE, 32'h1 << i);
      repeat (2) @(posedge pclk);
      chk(32'(pin.err_irq), 32'h1, "err irq");
      chk(32'(pin.tx_irq), 32'h0, "tx irq");
    end
    apb(1'b1, OFS_TX_CTRL, 32'h81);
    repeat (2) @(posedge pclk);
    chk(32'(pin.tx_irq), 32'h1, "tc irq");
    rx_stat <= ast_rx_stat_t'({8'h5A, 2'b11, 4'h0});
    apb(1'b1, OFS_CTRL_THREE, 32'h0);
    f = pulses;
    apb(1'b0, OFS_CTRL_THREE, 32'h0);
    chk(32'(rd[C3_RX_NINTH]), 32'h1, "rx ninth");
    apb(1'b0, OFS_DATA_PORT, 32'h0);
    chk(rd, 32'h5A, "rx data");
    repeat (3) @(posedge pclk);
    chk(pulses - f, 1, "rx read pulse");
    apb(1'b1, OFS_TX_CTRL, 32'h31);
    repeat (2) @(posedge pclk);
    chk(32'(pin.oe), 32'h0, "wire input");
    apb(1'b1, OFS_CTRL_THREE, 32'h20);
    repeat (2) @(posedge pclk);
    chk(32'(pin.oe), 32'h1, "wire output");
    end_sim();
  end
endmodule
`default_nettype wire
